// ===== logic/universal_serial_unit.sv
// Purpose: three-wire serial unit with shift register and edge counter
// Assumes: classic Wishbone slave, link pins sampled by clk_i
// Notes: two-wire mode and start detection are not built
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "usu_defines.svh"

module universal_serial_unit (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // timer compare tick, same clock
  input wire logic timer_match_i,
  // wake request
  output logic wake_o,
  // link
  usu_link_if.device link
);

  // ========================================================
  // state
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic ovf_q;
  logic [7:0] ctl_q;
  logic [2:0] port_q;
  logic do_q;
  logic do_oe_q;
  logic sck_m;
  logic sck_s;
  logic sck_p;
  logic di_m;
  logic di_s;
  logic ack_q;
  logic [31:0] rdata_q;
  logic wake_q;

  // ========================================================
  // bus decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    return a == o;
  endfunction : hit

  logic acc;
  logic wr;
  logic wr_data;
  logic wr_st;
  logic wr_ctl;
  logic wr_port;
  logic [7:0] wbyte;
  logic [7:0] ctl_eff;

  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  assign wr_data = wr & hit(wb_adr_i, `USU_OFS_DATA);
  assign wr_st = wr & hit(wb_adr_i, `USU_OFS_STATUS);
  assign wr_ctl = wr & hit(wb_adr_i, `USU_OFS_CONTROL);
  assign wr_port = wr & hit(wb_adr_i, `USU_OFS_PORT);
  // a control write acts with its own settings, so the first
  // write of a loop already clocks the way it configures
  assign ctl_eff = wr_ctl ? wbyte : ctl_q;

  // ========================================================
  // clock sources
  logic ext_clk;
  logic edge_sel;
  logic cnt_by_toggle;
  logic tc_stb;
  logic clk_stb;
  logic sck_rise;
  logic sck_fall;
  logic sample_edge;
  logic int_clk;
  logic shift_ev;
  logic count_ev;
  logic three_wire;
  logic latch_open;

  assign ext_clk = ctl_eff[`USU_CT_EXT_CLK];
  assign edge_sel = ctl_eff[`USU_CT_EDGE];
  assign cnt_by_toggle = ctl_eff[`USU_CT_CLK_STB];
  assign tc_stb = wr_ctl & wbyte[`USU_CT_TOGGLE];
  assign clk_stb = wr_ctl & wbyte[`USU_CT_CLK_STB];
  assign sck_rise = sck_s & ~sck_p;
  assign sck_fall = ~sck_s & sck_p;
  assign three_wire = ctl_q[`USU_CT_WM_HI:`USU_CT_WM_LO]
                      == usu_pkg::WM_THREE;
  // sample edge picked by edge select
  assign sample_edge = ext_clk &
    (edge_sel ? sck_fall : sck_rise);
  // internal source: software strobe or timer tick
  assign int_clk = ~ext_clk &
    (edge_sel ? timer_match_i : clk_stb);
  assign shift_ev = sample_edge | int_clk;
  // external clock counts both edges, or toggle writes
  assign count_ev = ext_clk ?
    (cnt_by_toggle ? tc_stb : (sck_rise | sck_fall))
    : int_clk;
  // latch open in the first half of an external cycle
  assign latch_open = ~ext_clk | (sck_s == edge_sel);

  // ========================================================
  // pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_p <= 1'b0;
      di_m <= 1'b0;
      di_s <= 1'b0;
    end else begin
      sck_m <= link.sck;
      sck_s <= sck_m;
      sck_p <= sck_s;
      di_m <= link.dev_di;
      di_s <= di_m;
    end
  end

  // ========================================================
  // shift register and counter next values
  always_comb begin
    data_d = data_q;
    if (wr_data) begin
      data_d = wbyte;
    end else if (shift_ev) begin
      data_d = {data_q[6:0], di_s};
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    if (wr_st) begin
      cnt_d = wbyte[`USU_ST_CNT_HI:0];
    end else if (count_ev) begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_q <= `USU_RST_BYTE;
      cnt_q <= `USU_RST_CNT;
    end else begin
      data_q <= data_d;
      cnt_q <= cnt_d;
    end
  end

  // ========================================================
  // overflow flag: a wrap in the clearing cycle still sets it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_q <= 1'b0;
    end else if (count_ev && cnt_q == `USU_CNT_MAX) begin
      ovf_q <= 1'b1;
    end else if (wr_st && wbyte[`USU_ST_OVF]) begin
      ovf_q <= 1'b0;
    end
  end

  // ========================================================
  // control and port registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= `USU_RST_BYTE;
    end else if (wr_ctl) begin
      // strobe bits are not kept except the count select
      ctl_q <= {wbyte[7:1], 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_q <= `USU_RST_PORT;
    end else if (wr_port) begin
      port_q <= wbyte[2:0];
    end else if (tc_stb) begin
      port_q[`USU_PT_SCK_OUT] <= ~port_q[`USU_PT_SCK_OUT];
    end
  end

  // ========================================================
  // data output latch and driver enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      do_q <= 1'b0;
    end else if (latch_open) begin
      // new msb shows at once while the latch is open
      do_q <= data_d[7];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      do_oe_q <= 1'b0;
    end else begin
      do_oe_q <= port_q[`USU_PT_DO_DIR] & three_wire;
    end
  end

  assign link.dev_do = do_q;
  assign link.dev_do_oe = do_oe_q;
  assign link.dev_sck = port_q[`USU_PT_SCK_OUT];
  assign link.dev_sck_oe = port_q[`USU_PT_SCK_DIR];

  // ========================================================
  // wake request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= ovf_q & ctl_q[`USU_CT_WAKE_EN];
    end
  end

  assign wake_o = wake_q;

  // ========================================================
  // bus answer: one wait state, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      rdata_q <= 32'h0000_0000;
      if (acc && !wb_we_i) begin
        if (hit(wb_adr_i, `USU_OFS_DATA)) begin
          rdata_q[7:0] <= data_q;
        end else if (hit(wb_adr_i, `USU_OFS_STATUS)) begin
          rdata_q[`USU_ST_OVF] <= ovf_q;
          rdata_q[`USU_ST_CNT_HI:0] <= cnt_q;
        end else if (hit(wb_adr_i, `USU_OFS_CONTROL)) begin
          rdata_q[7:0] <= ctl_q;
        end else if (hit(wb_adr_i, `USU_OFS_PORT)) begin
          rdata_q[2:0] <= port_q;
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule : universal_serial_unit

`default_nettype wire

// ===== logic/usu_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: byte addresses on a 4-bit Wishbone address
// Notes: definitions only
`ifndef USU_DEFINES_SVH
`define USU_DEFINES_SVH

// ==========================================================
// register offsets
`define USU_OFS_DATA 4'h0
`define USU_OFS_STATUS 4'h4
`define USU_OFS_CONTROL 4'h8
`define USU_OFS_PORT 4'hC

// ==========================================================
// status fields
`define USU_ST_OVF 6
`define USU_ST_CNT_HI 3

// ==========================================================
// control fields
`define USU_CT_WAKE_EN 7
`define USU_CT_WM_HI 5
`define USU_CT_WM_LO 4
`define USU_CT_EXT_CLK 3
`define USU_CT_EDGE 2
`define USU_CT_CLK_STB 1
`define USU_CT_TOGGLE 0

// ==========================================================
// port fields
`define USU_PT_SCK_OUT 0
`define USU_PT_SCK_DIR 1
`define USU_PT_DO_DIR 2

// ==========================================================
// reset values and counter limit
`define USU_RST_BYTE 8'h00
`define USU_RST_CNT 4'h0
`define USU_RST_PORT 3'h0
`define USU_CNT_MAX 4'hF

// ==========================================================
// timing of the partner's own serial clock
`define USU_CLK_PERIOD_NS 4
`define USU_HALF_SCK_NS 32
`define USU_HALF_SCK_CYC \
  ((`USU_HALF_SCK_NS + `USU_CLK_PERIOD_NS - 1) / `USU_CLK_PERIOD_NS)

`endif

// ===== logic/usu_pkg.sv
// Purpose: types of the two ends, wire modes for the unit and the partner sequence
// Assumes: nothing
// Notes: constants live in usu_defines.svh
package usu_pkg;

  // ========================================================
  // wire mode codes
  typedef enum logic [1:0] {
    WM_NONE = 2'b00,
    WM_THREE = 2'b01,
    WM_TWO = 2'b10,
    WM_TWO_HOLD = 2'b11
  } wire_mode_t;

  // ========================================================
  // partner sequence
  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_SETUP = 2'b01,
    P_RUN = 2'b11
  } partner_state_t;

endpackage : usu_pkg

// ===== logic/usu_link_if.sv
// Purpose: three-wire link between the unit and its partner
// Assumes: an undriven line reads low
// Notes: resolves each wire from the drivers' enables
`timescale 1ns/1ps
`default_nettype none

interface usu_link_if;
  logic dev_do;
  logic dev_do_oe;
  logic dev_sck;
  logic dev_sck_oe;
  logic par_do;
  logic par_do_oe;
  logic par_sck;
  logic par_sck_oe;
  logic sck;
  logic dev_di;
  logic par_di;

  // ========================================================
  // wire resolution
  assign sck = dev_sck_oe ? dev_sck : (par_sck_oe & par_sck);
  assign dev_di = par_do_oe & par_do;
  assign par_di = dev_do_oe & dev_do;

  modport device (
    output dev_do, output dev_do_oe, output dev_sck, output dev_sck_oe,
    input sck, input dev_di
  );
  modport partner (
    output par_do, output par_do_oe, output par_sck, output par_sck_oe,
    input sck, input par_di
  );
endinterface : usu_link_if

`default_nettype wire

// ===== logic/partner_serial_end.sv
// Purpose: spi mode 0/1 partner, master or slave, no select line
// Assumes: link clock idles low; user start is a one-cycle pulse
// Notes: as master it divides clk_i to make the serial clock
`timescale 1ns/1ps
`default_nettype none
`include "usu_defines.svh"

module partner_serial_end #(
  parameter int HALF_CYC = `USU_HALF_SCK_CYC
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // user side
  input wire logic master_i,
  input wire logic edge_sel_i,
  input wire logic release_i,
  input wire logic start_i,
  input wire logic [7:0] tx_data_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rx_data_o,
  // link
  usu_link_if.partner link
);

  usu_pkg::partner_state_t st_q;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [3:0] edges_q;
  logic [15:0] tmr_q;
  logic sck_q;
  logic sck_m;
  logic sck_s;
  logic sck_p;
  logic di_m;
  logic di_s;
  logic do_q;
  logic oe_q;
  logic done_q;
  logic [7:0] rx_q;
  logic sck_now;
  logic any_edge;
  logic sample_edge;

  // ========================================================
  // edge finding: own clock as master, synchronised as slave
  assign sck_now = master_i ? sck_q : sck_s;
  assign any_edge = (st_q == usu_pkg::P_RUN) & (sck_now ^ sck_p);
  assign sample_edge = any_edge & (sck_now ^ edge_sel_i);
  assign sh_d = start_i && st_q == usu_pkg::P_IDLE ? tx_data_i :
    (sample_edge ? {sh_q[6:0], di_s} : sh_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_p <= 1'b0;
      di_m <= 1'b0;
      di_s <= 1'b0;
    end else begin
      sck_m <= link.sck;
      sck_s <= sck_m;
      sck_p <= sck_now;
      di_m <= link.par_di;
      di_s <= di_m;
    end
  end

  // ========================================================
  // sequence: setup holds data half a cycle before clocking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= usu_pkg::P_IDLE;
      tmr_q <= 16'h0000;
      sck_q <= 1'b0;
      edges_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        usu_pkg::P_IDLE: begin
          edges_q <= 4'h0;
          tmr_q <= 16'(HALF_CYC - 1);
          if (start_i) begin
            st_q <= master_i ? usu_pkg::P_SETUP : usu_pkg::P_RUN;
          end
        end
        usu_pkg::P_SETUP: begin
          if (tmr_q == 16'h0000) begin
            st_q <= usu_pkg::P_RUN;
            tmr_q <= 16'(HALF_CYC - 1);
          end else begin
            tmr_q <= tmr_q - 16'h0001;
          end
        end
        usu_pkg::P_RUN: begin
          if (master_i && tmr_q == 16'h0000) begin
            sck_q <= ~sck_q;
            tmr_q <= 16'(HALF_CYC - 1);
          end else if (master_i) begin
            tmr_q <= tmr_q - 16'h0001;
          end
          if (any_edge) begin
            edges_q <= edges_q + 4'h1;
            if (edges_q == `USU_CNT_MAX) begin
              st_q <= usu_pkg::P_IDLE;
              done_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ========================================================
  // data, output latch and driver
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_q <= `USU_RST_BYTE;
      rx_q <= `USU_RST_BYTE;
      do_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      if (sck_now == edge_sel_i) begin
        do_q <= sh_d[7];
      end
      if (start_i && st_q == usu_pkg::P_IDLE) begin
        oe_q <= 1'b1;
      end else if (done_q && release_i) begin
        oe_q <= 1'b0;
      end
      if (done_q) begin
        rx_q <= sh_q;
      end
    end
  end

  assign link.par_do = do_q;
  assign link.par_do_oe = oe_q;
  assign link.par_sck = sck_q;
  assign link.par_sck_oe = master_i;
  assign busy_o = st_q != usu_pkg::P_IDLE;
  assign done_o = done_q;
  assign rx_data_o = rx_q;

endmodule : partner_serial_end

`default_nettype wire

// ===== bench/usu_link_assertions.sv
// Purpose: watch the three-wire link between the unit and its partner
// Assumes: one clock for both ends, partner half period of 8 cycles
// Notes: sees only the interface wires
`timescale 1ns/1ps
`default_nettype none

module usu_link_assertions (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // link wires
  input wire logic dev_do_oe,
  input wire logic dev_sck,
  input wire logic dev_sck_oe,
  input wire logic par_do_oe,
  input wire logic par_sck,
  input wire logic par_sck_oe,
  input wire logic sck
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ========================================================
  // drivers and clock ownership
  reset_quiet_a: assert property ($fell(rst_i) |->
    !dev_do_oe && !dev_sck_oe && !par_do_oe && !dev_sck)
    else $error("link drivers active after reset");
  clock_owner_a: assert property (!(dev_sck_oe && par_sck_oe))
    else $error("both ends drive the serial clock");
  wire_follow_a: assert property (dev_sck_oe |-> sck == dev_sck)
    else $error("serial clock wire ignores the unit");
  // each software toggle costs a full bus cycle
  toggle_gap_a: assert property (
    $changed(dev_sck) |=> $stable(dev_sck))
    else $error("unit clock toggled on consecutive cycles");

  // ========================================================
  // partner framing
  half_period_a: assert property (
    par_sck_oe && $changed(par_sck) |=> $stable(par_sck) [*7])
    else $error("partner half period shorter than 8 cycles");
  setup_lead_a: assert property (par_sck_oe && $rose(par_sck) |->
    $past(par_do_oe, 4))
    else $error("partner data not enabled before first edge");
  idle_low_a: assert property (
    $rose(par_do_oe) && par_sck_oe |-> !par_sck)
    else $error("partner clock not idle low at frame start");
  oe_hold_a: assert property ($rose(par_do_oe) |-> par_do_oe [*8])
    else $error("partner released data inside a frame");

  // ========================================================
  // scenarios reached
  unit_clock_c: cover property ($rose(dev_sck));
  partner_clock_c: cover property (par_sck_oe && $rose(par_sck));
  release_c: cover property ($fell(par_do_oe));
endmodule : usu_link_assertions

`default_nettype wire

// ===== bench/universal_serial_unit_bench.sv
// Purpose: exchange bytes between the unit and the partner end
// Assumes: wishbone answers one cycle after a request is taken
// Notes: byte select fixed to the low lane
`timescale 1ns/1ps
`default_nettype none

module universal_serial_unit_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic wake;
  logic master = 1'b0;
  logic edge_sel = 1'b0;
  logic rel = 1'b0;
  logic start = 1'b0;
  logic tmr = 1'b0;
  logic [7:0] ptx = 8'h00;
  logic pbusy;
  logic pdone;
  logic [7:0] prx;
  logic [31:0] rd;
  int mismatches = 0;
  int n_checks = 0;

  // ========================================================
  // ends and checker
  usu_link_if link();
  universal_serial_unit universal_serial_unit_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .timer_match_i(tmr), .wake_o(wake), .link(link.device));
  partner_serial_end #(.HALF_CYC(8)) partner_serial_end_i (
    .clk_i(clk_i), .rst_i(rst_i), .master_i(master), .edge_sel_i(edge_sel),
    .release_i(rel), .start_i(start), .tx_data_i(ptx), .busy_o(pbusy),
    .done_o(pdone), .rx_data_o(prx), .link(link.partner));
  usu_link_assertions usu_link_assertions_i (
    .clk_i(clk_i), .rst_i(rst_i), .dev_do_oe(link.dev_do_oe),
    .dev_sck(link.dev_sck), .dev_sck_oe(link.dev_sck_oe),
    .par_do_oe(link.par_do_oe), .par_sck(link.par_sck),
    .par_sck_oe(link.par_sck_oe), .sck(link.sck));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ========================================================
  // tasks
  task automatic finish_test();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // classic single cycle; only the watchdog ends the wait for ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e,
                       input string nm);
    wb(1'b0, a, 8'h00);
    check(nm, e, rd);
  endtask : rdchk

  task automatic pstart(input logic [7:0] d);
    @(posedge clk_i);
    ptx <= d;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
  endtask : pstart

  // done is a one-cycle pulse, so it is polled at every edge
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pdone !== 1'b1 && n < 600);
    if (pdone !== 1'b1) begin
      mismatches++;
    end
    // the received byte reaches the output one edge after done
    @(posedge clk_i);
  endtask : wait_done

  // gaps of 10 cycles keep the partner's synchroniser reliable
  task automatic run_master(input logic [7:0] ca, input logic [7:0] cb);
    for (int i = 0; i < 16; i++) begin
      wb(1'b1, 4'h8, i[0] ? cb : ca);
      repeat (10) @(posedge clk_i);
    end
  endtask : run_master

  // ========================================================
  // watchdog
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end

  // ========================================================
  // tests
  initial begin
    logic [7:0] flip;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 4'h2, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      rdchk((i < 4) ? 4'(i * 4) : 4'h2, 32'h0, "reset read");
    end
    wb(1'b1, 4'h8, 8'h10);
    wb(1'b1, 4'hC, 8'h04);
    repeat (2) @(posedge clk_i);
    check("data drive on", 32'h1, {31'h0, link.dev_do_oe});
    wb(1'b1, 4'hC, 8'h02);
    repeat (2) @(posedge clk_i);
    check("data drive off", 32'h0, {31'h0, link.dev_do_oe});
    // unit master by toggle writes, partner slave mode 0
    wb(1'b1, 4'hC, 8'h06);
    wb(1'b1, 4'h0, 8'hA5);
    wb(1'b1, 4'h4, 8'h40);
    pstart(8'h3C);
    fork
      run_master(8'h9B, 8'h9B);
      wait_done();
    join
    repeat (8) @(posedge clk_i);
    check("partner rx", 32'hA5, {24'h0, prx});
    rdchk(4'h4, 32'h40, "status wrap");
    rdchk(4'h0, 32'h3C, "data rx");
    rdchk(4'h8, 32'h9A, "control");
    check("wake", 32'h1, {31'h0, wake});
    wb(1'b1, 4'h4, 8'h4E);
    rdchk(4'h4, 32'h0E, "status load");
    repeat (2) @(posedge clk_i);
    check("wake clear", 32'h0, {31'h0, wake});
    // software strobe: toggle, then toggle with shift
    wb(1'b1, 4'h4, 8'h40);
    wb(1'b1, 4'h0, 8'h96);
    pstart(8'h69);
    fork
      run_master(8'h11, 8'h13);
      wait_done();
    join
    check("strobe partner rx", 32'h96, {24'h0, prx});
    rdchk(4'h4, 32'h08, "strobe count");
    rdchk(4'h0, 32'h69, "strobe data");
    // unit slave, partner master, both clock modes
    wb(1'b1, 4'hC, 8'h04);
    master <= 1'b1;
    rel <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      flip = {8{e[0]}};
      edge_sel <= e[0];
      wb(1'b1, 4'h8, 8'h18 | {5'h0, e[0], 2'h0});
      wb(1'b1, 4'h0, 8'h5A ^ flip);
      wb(1'b1, 4'h4, 8'h40);
      pstart(8'hC3 ^ flip);
      wait_done();
      check("slave rx", {24'h0, 8'h5A ^ flip}, {24'h0, prx});
      check("partner busy", 32'h0, {31'h0, pbusy});
      repeat (6) @(posedge clk_i);
      check("partner release", 32'h0, {31'h0, link.par_do_oe});
      rdchk(4'h4, 32'h40, "slave status");
      rdchk(4'h0, {24'h0, 8'hC3 ^ flip}, "slave data");
    end
    // timer source; a data write beats a tick in the same cycle
    wb(1'b1, 4'h8, 8'h14);
    wb(1'b1, 4'h4, 8'h40);
    fork
      wb(1'b1, 4'h0, 8'hA5);
      begin
        @(posedge clk_i);
        tmr <= 1'b1;
        @(posedge clk_i);
        tmr <= 1'b0;
      end
    join
    // released partner leaves the data wire low, so a zero shifts in
    @(posedge clk_i);
    tmr <= 1'b1;
    @(posedge clk_i);
    tmr <= 1'b0;
    rdchk(4'h0, 32'h4A, "timer shift");
    rdchk(4'h4, 32'h02, "timer count");
    finish_test();
  end
endmodule : universal_serial_unit_bench

`default_nettype wire
